// [design/scp_serial_port.sv]
`timescale 1ns/1ps

module scp_serial_port
  import scp_pkg::*;
#(
  parameter int BYTE_W = SCP_BYTE_W
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              portSelectN,
  input  wire logic              shiftClk,
  input  wire logic              serialIn,
  input  wire logic [BYTE_W-1:0] statusByte,
  output logic                   serialOut,
  output logic                   serialOutEn,
  output logic      [BYTE_W-1:0] cmdByte,
  output logic                   cmdValid,
  output logic                   captureRise
);

  // Pin synchronisers
  logic [2:0] pinsSync;
  logic       selNSync;
  logic       sckSync;
  logic       siSync;

  scp_sync #(
    .WIDTH  (3),
    .STAGES (SCP_SYNC_STAGES)
  ) u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({portSelectN, shiftClk, serialIn}),
    .syncOut (pinsSync)
  );

  assign selNSync = pinsSync[2];
  assign sckSync  = pinsSync[1];
  assign siSync   = pinsSync[0];

  // State
  scp_state_e              state_ff;
  scp_state_e              nxt_state;
  logic                    selNPrev_ff;
  logic                    sckPrev_ff;
  logic                    modeRise_ff;
  logic                    nxt_modeRise;
  logic [SCP_CNT_W-1:0]    bitCnt_ff;
  logic [SCP_CNT_W-1:0]    nxt_bitCnt;
  logic [BYTE_W-1:0]       rxShift_ff;
  logic [BYTE_W-1:0]       nxt_rxShift;
  logic [BYTE_W-1:0]       txShift_ff;
  logic [BYTE_W-1:0]       nxt_txShift;
  logic                    txHold_ff;
  logic                    nxt_txHold;
  logic [BYTE_W-1:0]       cmdByte_ff;
  logic [BYTE_W-1:0]       nxt_cmdByte;
  logic                    cmdValid_ff;
  logic                    nxt_cmdValid;
  logic                    serialOut_ff;
  logic                    nxt_serialOut;
  logic                    serialOutEn_ff;
  logic                    nxt_serialOutEn;
  logic [SCP_SYNC_STAGES-1:0] primed_ff;
  logic [SCP_SYNC_STAGES-1:0] nxt_primed;

  // Synchroniser shows its reset level until loaded from the pins;
  // acting on it would open a phantom frame with select really high
  assign nxt_primed = {primed_ff[SCP_SYNC_STAGES-2:0], SCP_LEVEL_HIGH};
  wire syncReady   = primed_ff[SCP_SYNC_STAGES-1];

  // Edge decode on synchronised levels only
  wire selHigh     = selNSync;
  wire selFallSeen = selNPrev_ff & ~selNSync;
  wire sckRise     = sckSync & ~sckPrev_ff;
  wire sckFall     = ~sckSync & sckPrev_ff;
  wire isActive    = (state_ff == SCP_ST_ACTIVE);
  wire enterActive = (state_ff == SCP_ST_IDLE) & ~selHigh & syncReady;

  // Capture and launch edges follow the latched polarity
  wire captureEdge = isActive & ~selHigh & (modeRise_ff ? sckRise : sckFall);
  wire launchEdge  = isActive & ~selHigh & (modeRise_ff ? sckFall : sckRise);
  wire lastBit     = (bitCnt_ff == SCP_CNT_LAST);
  wire byteDone    = captureEdge & lastBit;

  // Next-state selection
  always_comb begin
    nxt_state = state_ff;
    if (selHigh) begin
      nxt_state = SCP_ST_IDLE;
    end else if (enterActive) begin
      nxt_state = SCP_ST_ACTIVE;
    end
  end

  // Polarity is fixed for the whole transfer once select is low
  always_comb begin
    nxt_modeRise = modeRise_ff;
    if (enterActive) begin
      if (selFallSeen) begin
        nxt_modeRise = sckSync;
      end else begin
        nxt_modeRise = SCP_MODE_RISE;
      end
    end
  end

  // Bit counter and receive shifter
  always_comb begin
    nxt_bitCnt  = bitCnt_ff;
    nxt_rxShift = rxShift_ff;
    if (selHigh) begin
      nxt_bitCnt = SCP_CNT_ZERO;
    end else if (captureEdge) begin
      nxt_rxShift = {rxShift_ff[BYTE_W-2:0], siSync};
      if (lastBit) begin
        nxt_bitCnt = SCP_CNT_ZERO;
      end else begin
        nxt_bitCnt = bitCnt_ff + SCP_CNT_ONE;
      end
    end
  end

  // Completed command byte, one-cycle strobe
  always_comb begin
    nxt_cmdByte  = cmdByte_ff;
    nxt_cmdValid = SCP_LEVEL_LOW;
    if (byteDone) begin
      nxt_cmdByte  = {rxShift_ff[BYTE_W-2:0], siSync};
      nxt_cmdValid = SCP_LEVEL_HIGH;
    end
  end

  // Status transmit path.
  // The first edge after select fall is always a launch edge in either
  // mode; txHold keeps MSB on the line through it so the host still
  // samples bit 7 at the first capture edge.
  always_comb begin
    nxt_txShift     = txShift_ff;
    nxt_txHold      = txHold_ff;
    nxt_serialOut   = serialOut_ff;
    nxt_serialOutEn = serialOutEn_ff;
    if (selHigh) begin
      nxt_serialOutEn = SCP_LEVEL_LOW;
      nxt_txHold      = SCP_LEVEL_HIGH;
    end else if (enterActive || byteDone) begin
      nxt_txShift     = statusByte;
      nxt_serialOut   = statusByte[BYTE_W-1];
      nxt_txHold      = SCP_LEVEL_HIGH;
      nxt_serialOutEn = SCP_LEVEL_HIGH;
    end else begin
      if (captureEdge) begin
        nxt_txHold = SCP_LEVEL_LOW;
      end
      if (launchEdge && !txHold_ff) begin
        nxt_txShift   = {txShift_ff[BYTE_W-2:0], SCP_LEVEL_LOW};
        nxt_serialOut = txShift_ff[BYTE_W-2];
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff    <= SCP_ST_IDLE;
      selNPrev_ff <= SCP_LEVEL_LOW;
      sckPrev_ff  <= SCP_LEVEL_LOW;
      modeRise_ff <= SCP_MODE_RISE;
      primed_ff   <= '0;
    end else begin
      state_ff    <= nxt_state;
      primed_ff   <= nxt_primed;
      selNPrev_ff <= selNSync;
      sckPrev_ff  <= sckSync;
      modeRise_ff <= nxt_modeRise;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bitCnt_ff  <= SCP_CNT_ZERO;
      rxShift_ff <= SCP_BYTE_RST;
      cmdByte_ff <= SCP_BYTE_RST;
      cmdValid_ff <= SCP_LEVEL_LOW;
    end else begin
      bitCnt_ff  <= nxt_bitCnt;
      rxShift_ff <= nxt_rxShift;
      cmdByte_ff <= nxt_cmdByte;
      cmdValid_ff <= nxt_cmdValid;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txShift_ff     <= SCP_BYTE_RST;
      txHold_ff      <= SCP_LEVEL_HIGH;
      serialOut_ff   <= SCP_LEVEL_LOW;
      serialOutEn_ff <= SCP_LEVEL_LOW;
    end else begin
      txShift_ff     <= nxt_txShift;
      txHold_ff      <= nxt_txHold;
      serialOut_ff   <= nxt_serialOut;
      serialOutEn_ff <= nxt_serialOutEn;
    end
  end

  assign serialOut   = serialOut_ff;
  assign serialOutEn = serialOutEn_ff;
  assign cmdByte     = cmdByte_ff;
  assign cmdValid    = cmdValid_ff;
  assign captureRise = modeRise_ff;

endmodule : scp_serial_port

// [design/scp_sync.sv]
`timescale 1ns/1ps

// Multi-bit two-flop synchroniser; every bit is an independent level.
module scp_sync
  import scp_pkg::*;
#(
  parameter int WIDTH  = 3,
  parameter int STAGES = SCP_SYNC_STAGES
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage_ff [STAGES];

  // Only the next stage reads a stage; the last stage is the output.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_ff[i] <= '0;
      end
    end else begin
      stage_ff[0] <= asyncIn;
      for (int i = 1; i < STAGES; i++) begin
        stage_ff[i] <= stage_ff[i-1];
      end
    end
  end

  assign syncOut = stage_ff[STAGES-1];

endmodule : scp_sync

// [inc/scp_pkg.sv]
package scp_pkg;

  // Frame geometry
  localparam int          SCP_BYTE_W    = 8;
  localparam int          SCP_CNT_W     = 3;
  localparam logic [2:0]  SCP_CNT_ZERO  = 3'h0;
  localparam logic [2:0]  SCP_CNT_ONE   = 3'h1;
  localparam logic [2:0]  SCP_CNT_LAST  = 3'h7;

  // Synchroniser depth for pins
  localparam int          SCP_SYNC_STAGES = 2;

  // Reset values
  localparam logic [7:0]  SCP_BYTE_RST    = 8'h00;
  localparam logic        SCP_LEVEL_LOW   = 1'b0;
  localparam logic        SCP_LEVEL_HIGH  = 1'b1;
  // Capture-on-rising is the mode used when no select falling edge is seen
  localparam logic        SCP_MODE_RISE   = 1'b1;

  // Port state
  typedef enum logic [0:0] {
    SCP_ST_IDLE   = 1'b0,
    SCP_ST_ACTIVE = 1'b1
  } scp_state_e;

endpackage : scp_pkg

// [tb/scp_host_model.sv]
`timescale 1ns/1ps
module scp_host_model (
  input  wire logic clk,
  input  wire logic soPin,
  output logic      portSelectN,
  output logic      shiftClk,
  output logic      serialIn
);
  initial begin
    portSelectN = 1'b0;
    shiftClk = 1'b0;
    serialIn = 1'b0;
  end
  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask : waitn
  task automatic open(input logic idle);
    shiftClk = idle;
    waitn(8);
    portSelectN = 1'b0;
    waitn(8);
  endtask : open
  // Released data line must not look like the last bit
  task automatic close();
    portSelectN = 1'b1;
    serialIn = ~serialIn;
    waitn(8);
  endtask : close
  // Data moves two cycles after the first toggle of a bit, so a device
  // sampling on the wrong edge sees the neighbouring bit
  task automatic shift(input logic [7:0] tx, input int nb, input logic capFirst,
                       output logic [7:0] rx);
    rx = 8'h00;
    if (capFirst) serialIn = tx[7];
    waitn(2);
    for (int i = 7; i > 7 - nb; i--) begin
      if (capFirst) rx[i] = soPin;
      shiftClk = ~shiftClk;
      waitn(2);
      serialIn = capFirst ? tx[(i + 7) % 8] : tx[i];
      waitn(2);
      if (!capFirst) rx[i] = soPin;
      shiftClk = ~shiftClk;
      waitn(4);
    end
    waitn(8);
  endtask : shift
endmodule : scp_host_model

// [tb/scp_serial_port_chk.sv]
`timescale 1ns/1ps
module scp_serial_port_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       portSelectN,
  input wire logic       shiftClk,
  input wire logic       serialOutEn,
  input wire logic [7:0] cmdByte,
  input wire logic       cmdValid,
  input wire logic       captureRise
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_idle; portSelectN [*4]; endsequence
  sequence s_sel; !portSelectN [*6]; endsequence
  property p_off; s_idle |-> !serialOutEn; endproperty
  a_off: assert property (p_off) else $error("output not released");
  property p_on; s_sel |-> serialOutEn; endproperty
  a_on: assert property (p_on) else $error("output not driven");
  property p_pulse; cmdValid |=> !cmdValid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_hold; !cmdValid |-> $stable(cmdByte); endproperty
  a_hold: assert property (p_hold) else $error("byte moved");
  property p_drop; s_idle |-> !cmdValid; endproperty
  a_drop: assert property (p_drop) else $error("valid while idle");
  property p_insel; cmdValid |-> serialOutEn; endproperty
  a_insel: assert property (p_insel) else $error("valid outside frame");
  property p_when; $changed(captureRise) |-> $rose(serialOutEn); endproperty
  a_when: assert property (p_when) else $error("mode moved in frame");
  // Frames opened by a real select fall only; reset-low start is separate
  property p_lvl;
    $rose(serialOutEn) && $past(portSelectN, 6) |-> captureRise == $past(shiftClk, 2);
  endproperty
  a_lvl: assert property (p_lvl) else $error("wrong clock sense");
endmodule : scp_serial_port_chk
bind scp_serial_port scp_serial_port_chk u_chk (.*);

// [tb/scp_serial_port_tb.sv]
`timescale 1ns/1ps
module scp_serial_port_tb;
  logic       clk;
  logic       sys_rst;
  logic       portSelectN;
  logic       shiftClk;
  logic       serialIn;
  logic [7:0] statusByte;
  logic       serialOut;
  logic       serialOutEn;
  logic [7:0] cmdByte;
  logic       cmdValid;
  logic       captureRise;
  logic [7:0] lastByte;
  logic [7:0] rx;
  int         nValid = 0;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cyc = 0;
  // No pull on the pin: a released line shows the inverse of the last bit
  wire        soPin = serialOutEn ? serialOut : ~serialOut;
  scp_serial_port u_scp_serial_port (.clk(clk), .sys_rst(sys_rst),
    .portSelectN(portSelectN), .shiftClk(shiftClk), .serialIn(serialIn),
    .statusByte(statusByte), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .cmdByte(cmdByte), .cmdValid(cmdValid), .captureRise(captureRise));
  scp_host_model u_scp_host_model (.clk(clk), .soPin(soPin),
    .portSelectN(portSelectN), .shiftClk(shiftClk), .serialIn(serialIn));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmdValid === 1'b1) begin
      nValid <= nValid + 1;
      lastByte <= cmdByte;
    end
    if (cyc == 4000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Select low since reset, shift clock low: first toggle is a rising capture
  task automatic t_default();
    chk({7'h00, captureRise}, 8'h01);
    u_scp_host_model.shift(8'hA5, 8, 1'b1, rx);
    chk(rx, 8'h3C);
    chk(lastByte, 8'hA5);
    u_scp_host_model.close();
    chk({7'h00, serialOutEn}, 8'h00);
  endtask : t_default
  task automatic t_mode(input logic idle, input logic [7:0] st);
    int n0;
    n0 = nValid;
    statusByte = st;
    u_scp_host_model.open(idle);
    chk({7'h00, captureRise}, {7'h00, idle});
    u_scp_host_model.shift(~st, 8, 1'b0, rx);
    chk(rx, st);
    chk(lastByte, ~st);
    u_scp_host_model.shift(st, 8, 1'b0, rx);
    chk(rx, st);
    chk(lastByte, st);
    chk(8'(nValid - n0), 8'h02);
    u_scp_host_model.close();
  endtask : t_mode
  task automatic t_partial();
    int n0;
    n0 = nValid;
    u_scp_host_model.open(1'b1);
    u_scp_host_model.shift(8'hFF, 5, 1'b0, rx);
    u_scp_host_model.close();
    chk(8'(nValid - n0), 8'h00);
    u_scp_host_model.open(1'b1);
    u_scp_host_model.shift(8'h81, 8, 1'b0, rx);
    chk(lastByte, 8'h81);
    u_scp_host_model.close();
  endtask : t_partial
  // Reset with select high must not open a phantom frame
  task automatic t_rst();
    logic seen;
    seen = 1'b0;
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) begin
      @(negedge clk);
      seen = seen | serialOutEn;
    end
    chk({7'h00, seen}, 8'h00);
    chk({7'h00, captureRise}, 8'h01);
  endtask : t_rst
  initial begin
    sys_rst = 1'b1;
    statusByte = 8'h3C;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    t_default();
    t_mode(1'b1, 8'h96);
    t_mode(1'b0, 8'h4B);
    t_partial();
    t_rst();
    end_sim();
  end
endmodule : scp_serial_port_tb
